// ---- fpcg_top.v ----
// Function
// - Reset clears trap, watch and native-error flags.
// - Trap flag set faults every floating-point instruction.
// - Watch clear: check ops ignore task-switched flag.
// - Watch and task-switched set: check op faults.
// - Native flag picks internal or external error.
// - No-FPU build faults every floating-point instruction.
// - Reset sets cache-off flags; clearing both enables.
// - All cache lines invalid after reset.
// - Page bits control caching per page.
// - Memory-type range value zero means uncached.
// - Model registers reached only by dedicated ops.
// - Query reports SIMD levels at 25, 26, 0.
// - Query reports context ops bit 24, flush 19.
// - Query leaf one loads feature words.
// - Extended word bit 9 is simd save flag.
// - Extended word bit 10 is simd fault flag.
// - Reset loads simd status 1F80; soft init keeps.
`timescale 1ns/1ns
`include "fpcg_defs.vh"

module fpcg_top
#(
    parameter FPU_PRESENT = 1,
    parameter [31:0] FEAT_R1_OTHER = 32'h00000000,
    parameter [31:0] FEAT_R2_OTHER = 32'h00000000
)
(
    // Clock and reset
    input wire core_clk_i,
    input wire rstn_i,
    input wire soft_init_i,
    // Control word writes
    input wire mcw0_wr_i,
    input wire [31:0] mcw0_wdata_i,
    input wire ecw_wr_i,
    input wire [31:0] ecw_wdata_i,
    // Control word state
    output wire [31:0] mcw0_o,
    output wire [31:0] ecw_o,
    output wire os_simd_save_flag_o,
    output wire os_simd_fault_flag_o,
    // Instruction issue
    input wire fp_op_i,
    input wire pending_fp_check_op_i,
    input wire fp_unmasked_err_i,
    output wire dev_unavail_o,
    output wire fp_err_internal_o,
    output wire fp_err_external_o,
    // Caching
    input wire page_cache_off_i,
    input wire page_write_through_i,
    input wire [7:0] range_type_sel_i,
    output wire cache_enable_o,
    output wire access_cacheable_o,
    output wire access_write_through_o,
    input wire fill_i,
    input wire [`FPCG_CACHE_IDX_W-1:0] fill_idx_i,
    input wire [`FPCG_CACHE_IDX_W-1:0] look_idx_i,
    output wire look_valid_o,
    // Model register access
    input wire model_reg_read_op_i,
    input wire model_reg_write_op_i,
    input wire [31:0] model_reg_idx_i,
    input wire [31:0] model_reg_wdata_i,
    output reg [31:0] model_reg_rdata_o,
    output reg model_reg_fault_o,
    // Identification query
    input wire ident_query_i,
    input wire [31:0] ident_leaf_i,
    output reg [31:0] ident_r1_o,
    output reg [31:0] ident_r2_o
);

    reg [31:0] mcw0_q;
    reg [31:0] mcw0_d;
    reg [31:0] ecw_q;
    reg [31:0] ecw_d;
    reg [31:0] scs_q;
    reg [7:0] mtr0_q;
    reg [7:0] mtr1_q;
    reg [7:0] range_type;
    reg ident_hit;

    // Writes land at the edge, so the next issued instruction sees them.
    always @*
    begin
        mcw0_d = mcw0_q;
        if (mcw0_wr_i)
            mcw0_d = mcw0_wdata_i;
        ecw_d = ecw_q;
        if (ecw_wr_i)
            ecw_d = ecw_wdata_i;
    end

    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            mcw0_q <= `FPCG_MCW0_RESET;
            ecw_q <= `FPCG_ECW_RESET;
        end
        else if (soft_init_i)
        begin
            // Soft init keeps the cache-off flags, sets bit 4, clears the rest.
            mcw0_q <= (mcw0_q & ((32'h1 << `FPCG_MCW0_CACHE_DIS) | (32'h1 << `FPCG_MCW0_NO_WB)))
                | 32'h00000010;
            ecw_q <= `FPCG_ECW_RESET;
        end
        else
        begin
            mcw0_q <= mcw0_d;
            ecw_q <= ecw_d;
        end
    end

    assign mcw0_o = mcw0_q;
    assign ecw_o = ecw_q;
    assign os_simd_save_flag_o = ecw_q[`FPCG_ECW_SIMD_SAVE];
    assign os_simd_fault_flag_o = ecw_q[`FPCG_ECW_SIMD_FAULT];

    // Fault decisions use the committed flags only.
    fpcg_fault_decode u_fault
    (
        .soft_fp_trap_flag_i(mcw0_q[`FPCG_MCW0_SOFT_TRAP]),
        .wait_coproc_watch_flag_i(mcw0_q[`FPCG_MCW0_WAIT_WATCH]),
        .native_error_flag_i(mcw0_q[`FPCG_MCW0_NATIVE_ERR]),
        .task_switched_flag_i(mcw0_q[`FPCG_MCW0_TASK_SW]),
        .fpu_present_i(FPU_PRESENT != 0),
        .fp_op_i(fp_op_i),
        .pending_fp_check_op_i(pending_fp_check_op_i),
        .fp_unmasked_err_i(fp_unmasked_err_i),
        .dev_unavail_o(dev_unavail_o),
        .fp_err_internal_o(fp_err_internal_o),
        .fp_err_external_o(fp_err_external_o)
    );

    // Caches run only with both cache-off flags clear.
    assign cache_enable_o = ~mcw0_q[`FPCG_MCW0_CACHE_DIS] & ~mcw0_q[`FPCG_MCW0_NO_WB];

    always @*
    begin
        range_type = range_type_sel_i[0] ? mtr1_q : mtr0_q;
    end

    assign access_cacheable_o = cache_enable_o & ~page_cache_off_i
        & (range_type != `FPCG_MT_UNCACHED);
    assign access_write_through_o = access_cacheable_o & page_write_through_i;

    fpcg_cache_valid u_valid
    (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .fill_i(fill_i & cache_enable_o),
        .fill_idx_i(fill_idx_i),
        .look_idx_i(look_idx_i),
        .look_valid_o(look_valid_o)
    );

    // Model registers: range types and simd status, only via the dedicated ops.
    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            mtr0_q <= `FPCG_MT_UNCACHED;
            mtr1_q <= `FPCG_MT_UNCACHED;
            scs_q <= `FPCG_SCS_RESET;
        end
        else if (model_reg_write_op_i && !soft_init_i)
        begin
            if (model_reg_idx_i == `FPCG_MSR_MTR0)
                mtr0_q <= model_reg_wdata_i[7:0];
            if (model_reg_idx_i == `FPCG_MSR_MTR1)
                mtr1_q <= model_reg_wdata_i[7:0];
            if (model_reg_idx_i == `FPCG_MSR_SCS)
                scs_q <= model_reg_wdata_i;
        end
    end

    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            model_reg_rdata_o <= 32'h00000000;
            model_reg_fault_o <= 1'b0;
        end
        else
        begin
            model_reg_fault_o <= 1'b0;
            if (model_reg_read_op_i)
            begin
                case (model_reg_idx_i)
                    `FPCG_MSR_MTR0: model_reg_rdata_o <= {24'h000000, mtr0_q};
                    `FPCG_MSR_MTR1: model_reg_rdata_o <= {24'h000000, mtr1_q};
                    `FPCG_MSR_SCS: model_reg_rdata_o <= scs_q;
                    default:
                    begin
                        model_reg_rdata_o <= 32'h00000000;
                        model_reg_fault_o <= 1'b1;
                    end
                endcase
            end
            else if (model_reg_write_op_i)
            begin
                case (model_reg_idx_i)
                    `FPCG_MSR_MTR0, `FPCG_MSR_MTR1, `FPCG_MSR_SCS: model_reg_fault_o <= 1'b0;
                    default: model_reg_fault_o <= 1'b1;
                endcase
            end
        end
    end

    // Identification query.
    always @*
    begin
        ident_hit = ident_query_i && (ident_leaf_i == `FPCG_ID_LEAF_FEATURES);
    end

    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            ident_r1_o <= 32'h00000000;
            ident_r2_o <= 32'h00000000;
        end
        else if (ident_hit)
        begin
            ident_r1_o <= FEAT_R1_OTHER
                | (32'h1 << `FPCG_ID_R1_SIMD_L1)
                | (32'h1 << `FPCG_ID_R1_SIMD_L2)
                | (32'h1 << `FPCG_ID_R1_CTX_SAVE)
                | (32'h1 << `FPCG_ID_R1_LINE_FLUSH);
            ident_r2_o <= FEAT_R2_OTHER | (32'h1 << `FPCG_ID_R2_SIMD_L3);
        end
        else if (ident_query_i)
        begin
            ident_r1_o <= 32'h00000000;
            ident_r2_o <= 32'h00000000;
        end
    end

endmodule

// ---- fpcg_defs.vh ----
`ifndef FPCG_DEFS_VH
`define FPCG_DEFS_VH

// Bit positions inside machine_control_word0.
`define FPCG_MCW0_WAIT_WATCH 1
`define FPCG_MCW0_SOFT_TRAP 2
`define FPCG_MCW0_TASK_SW 3
`define FPCG_MCW0_NATIVE_ERR 5
`define FPCG_MCW0_NO_WB 29
`define FPCG_MCW0_CACHE_DIS 30
// Reset value: cache_disable_flag and no_writeback_flag set, bit 4 set.
`define FPCG_MCW0_RESET 32'h60000010

// Bit positions inside ext_control_word.
`define FPCG_ECW_SIMD_SAVE 9
`define FPCG_ECW_SIMD_FAULT 10
`define FPCG_ECW_RESET 32'h00000000

// simd_ctrl_status reset value.
`define FPCG_SCS_RESET 32'h00001F80

// Identification query feature bits.
`define FPCG_ID_LEAF_FEATURES 32'h00000001
`define FPCG_ID_R1_LINE_FLUSH 19
`define FPCG_ID_R1_CTX_SAVE 24
`define FPCG_ID_R1_SIMD_L1 25
`define FPCG_ID_R1_SIMD_L2 26
`define FPCG_ID_R2_SIMD_L3 0

// Memory type codes.
`define FPCG_MT_UNCACHED 8'h00

// Cache line count; reset invalidates every line in the same cycle.
`define FPCG_CACHE_LINES 64
`define FPCG_CACHE_IDX_W 6

// Model register indexes held locally.
`define FPCG_MSR_MTR0 32'h00000200
`define FPCG_MSR_MTR1 32'h00000201
`define FPCG_MSR_SCS 32'h00000202

`endif

// ---- fpcg_fault_decode.v ----
`timescale 1ns/1ns
`include "fpcg_defs.vh"

module fpcg_fault_decode
(
    // Flags
    input wire soft_fp_trap_flag_i,
    input wire wait_coproc_watch_flag_i,
    input wire native_error_flag_i,
    input wire task_switched_flag_i,
    input wire fpu_present_i,
    // Instruction class
    input wire fp_op_i,
    input wire pending_fp_check_op_i,
    input wire fp_unmasked_err_i,
    // Results
    output wire dev_unavail_o,
    output wire fp_err_internal_o,
    output wire fp_err_external_o
);

    wire fp_trap;
    wire wait_trap;

    assign fp_trap = fp_op_i & (soft_fp_trap_flag_i | ~fpu_present_i);
    assign wait_trap = pending_fp_check_op_i & wait_coproc_watch_flag_i & task_switched_flag_i;
    assign dev_unavail_o = fp_trap | wait_trap;
    assign fp_err_internal_o = fp_unmasked_err_i & native_error_flag_i;
    assign fp_err_external_o = fp_unmasked_err_i & ~native_error_flag_i;

endmodule

// ---- fpcg_cache_valid.v ----
`timescale 1ns/1ns
`include "fpcg_defs.vh"

module fpcg_cache_valid
(
    // Clock and reset
    input wire core_clk_i,
    input wire rstn_i,
    // Line fill and lookup
    input wire fill_i,
    input wire [`FPCG_CACHE_IDX_W-1:0] fill_idx_i,
    input wire [`FPCG_CACHE_IDX_W-1:0] look_idx_i,
    output reg look_valid_o
);

    reg [`FPCG_CACHE_LINES-1:0] valid_q;

    genvar i;
    generate
        for (i = 0; i < `FPCG_CACHE_LINES; i = i + 1)
        begin : g_line
            always @(posedge core_clk_i)
            begin
                if (!rstn_i)
                    valid_q[i] <= 1'b0;
                else if (fill_i && (fill_idx_i == i))
                    valid_q[i] <= 1'b1;
            end
        end
    endgenerate

    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
            look_valid_o <= 1'b0;
        else
            look_valid_o <= valid_q[look_idx_i];
    end

endmodule

// ---- fpcg_chk.sv ----
`timescale 1ns/1ns
module fpcg_chk
#(
    parameter FPU_PRESENT = 1
)
(
    // Clock and reset
    input wire core_clk_i,
    input wire rstn_i,
    // Watched ports
    input wire mcw0_wr_i,
    input wire [31:0] mcw0_wdata_i,
    input wire [31:0] mcw0_o,
    input wire [31:0] ecw_o,
    input wire os_simd_save_flag_o,
    input wire os_simd_fault_flag_o,
    input wire fp_op_i,
    input wire pending_fp_check_op_i,
    input wire fp_unmasked_err_i,
    input wire dev_unavail_o,
    input wire fp_err_internal_o,
    input wire fp_err_external_o,
    input wire page_cache_off_i,
    input wire page_write_through_i,
    input wire cache_enable_o,
    input wire access_cacheable_o,
    input wire access_write_through_o,
    input wire ident_query_i,
    input wire [31:0] ident_leaf_i,
    input wire [31:0] ident_r1_o,
    input wire [31:0] ident_r2_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_leaf_one;
        ident_query_i && ident_leaf_i == 32'h00000001;
    endsequence
    sequence s_feat_words;
        ident_r1_o[26:24] == 3'h7 && ident_r1_o[19] && ident_r2_o[0];
    endsequence
    chk_reset_word: assert property (disable iff (1'b0) !rstn_i |=> mcw0_o == 32'h60000010)
        else $error("control word not at reset value");
    chk_fault_gate: assert property (dev_unavail_o == ((fp_op_i && (mcw0_o[2] || FPU_PRESENT == 0))
        || (pending_fp_check_op_i && mcw0_o[1] && mcw0_o[3]))) else $error("wrong unavailable fault");
    chk_err_route: assert property (fp_err_internal_o == (fp_unmasked_err_i && mcw0_o[5])
        && fp_err_external_o == (fp_unmasked_err_i && !mcw0_o[5])) else $error("wrong error route");
    chk_write_next: assert property (mcw0_wr_i |=> mcw0_o == $past(mcw0_wdata_i))
        else $error("control write not seen next cycle");
    chk_cache_gate: assert property (cache_enable_o == !(mcw0_o[30] || mcw0_o[29]))
        else $error("cache enable wrong");
    chk_page_off: assert property (access_cacheable_o |-> cache_enable_o && !page_cache_off_i)
        else $error("uncached page cached");
    chk_write_thru: assert property (access_write_through_o == (access_cacheable_o && page_write_through_i))
        else $error("write through wrong");
    chk_ident_feat: assert property (s_leaf_one |=> s_feat_words)
        else $error("feature bits missing");
    chk_simd_flags: assert property (os_simd_save_flag_o == ecw_o[9] && os_simd_fault_flag_o == ecw_o[10])
        else $error("simd flags wrong");
endmodule
bind fpcg_top fpcg_chk #(.FPU_PRESENT(FPU_PRESENT)) fpcg_chk_i (.core_clk_i, .rstn_i, .mcw0_wr_i, .mcw0_wdata_i,
    .mcw0_o, .ecw_o, .os_simd_save_flag_o, .os_simd_fault_flag_o, .fp_op_i, .pending_fp_check_op_i,
    .fp_unmasked_err_i, .dev_unavail_o, .fp_err_internal_o, .fp_err_external_o, .page_cache_off_i,
    .page_write_through_i, .cache_enable_o, .access_cacheable_o, .access_write_through_o, .ident_query_i,
    .ident_leaf_i, .ident_r1_o, .ident_r2_o);

// ---- tb_fpcg_top.sv ----
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_fpcg_top;
    reg core_clk_i = 0, rstn_i = 0, soft_init_i = 0, mcw0_wr_i = 0, ecw_wr_i = 0, fp_op_i = 0, fill_i = 0;
    reg pending_fp_check_op_i = 0, fp_unmasked_err_i = 0, page_cache_off_i = 0, page_write_through_i = 0;
    reg model_reg_read_op_i = 0, model_reg_write_op_i = 0, ident_query_i = 0;
    reg [31:0] mcw0_wdata_i = 0, ecw_wdata_i = 0, model_reg_idx_i = 0, model_reg_wdata_i = 0, ident_leaf_i = 0;
    reg [7:0] range_type_sel_i = 0;
    reg [5:0] fill_idx_i = 0, look_idx_i = 0;
    wire [31:0] mcw0_o, ecw_o, model_reg_rdata_o, ident_r1_o, ident_r2_o;
    wire os_simd_save_flag_o, os_simd_fault_flag_o, dev_unavail_o, fp_err_internal_o, fp_err_external_o;
    wire cache_enable_o, access_cacheable_o, access_write_through_o, look_valid_o, model_reg_fault_o;
    wire nofpu_dev_unavail;
    integer n_fail = 0, n_compared = 0, cyc = 0, i;
    reg [31:0] r = 32'h00013E8E, v;
    reg [2:0] c;
    fpcg_top #(.FPU_PRESENT(1)) fpcg_top_i (.*);
    // Second build without floating-point hardware shares every input.
    fpcg_top #(.FPU_PRESENT(0)) fpcg_top_nofpu_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .soft_init_i(soft_init_i), .mcw0_wr_i(mcw0_wr_i), .mcw0_wdata_i(mcw0_wdata_i), .ecw_wr_i(ecw_wr_i),
        .ecw_wdata_i(ecw_wdata_i), .mcw0_o(), .ecw_o(), .os_simd_save_flag_o(), .os_simd_fault_flag_o(),
        .fp_op_i(fp_op_i), .pending_fp_check_op_i(pending_fp_check_op_i), .fp_unmasked_err_i(fp_unmasked_err_i),
        .dev_unavail_o(nofpu_dev_unavail), .fp_err_internal_o(), .fp_err_external_o(),
        .page_cache_off_i(page_cache_off_i), .page_write_through_i(page_write_through_i),
        .range_type_sel_i(range_type_sel_i), .cache_enable_o(), .access_cacheable_o(),
        .access_write_through_o(), .fill_i(fill_i), .fill_idx_i(fill_idx_i), .look_idx_i(look_idx_i),
        .look_valid_o(), .model_reg_read_op_i(model_reg_read_op_i), .model_reg_write_op_i(model_reg_write_op_i),
        .model_reg_idx_i(model_reg_idx_i), .model_reg_wdata_i(model_reg_wdata_i), .model_reg_rdata_o(),
        .model_reg_fault_o(), .ident_query_i(ident_query_i), .ident_leaf_i(ident_leaf_i), .ident_r1_o(),
        .ident_r2_o());
    always #25 core_clk_i = ~core_clk_i;
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function [2:0] exp_fp(input [31:0] m, input [2:0] k);
        exp_fp = {(k[2] & m[2]) | (k[1] & m[1] & m[3]), k[0] & m[5], k[0] & ~m[5]};
    endfunction
    task tick;
    begin
        @(posedge core_clk_i);
        #5;
    end
    endtask
    task mreg(input rd, input [31:0] idx, input [31:0] wd);
    begin
        model_reg_read_op_i = rd;
        model_reg_write_op_i = !rd;
        model_reg_idx_i = idx;
        model_reg_wdata_i = wd;
        tick;
        model_reg_read_op_i = 0;
        model_reg_write_op_i = 0;
    end
    endtask
    task end_sim;
    begin
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    // Ceiling of 3000 cycles is far above the expected run of about 83 cycles, so a hung test cannot stall forever.
    always @(posedge core_clk_i)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            n_fail++;
            end_sim;
        end
    end
    initial
    begin
        look_idx_i = 6'h2A;
        repeat (10) tick;
        rstn_i = 1;
        tick;
        `CHK("mcw0", 32'h60000010, mcw0_o)
        `CHK("cache_en", 1'b0, cache_enable_o)
        `CHK("line_valid", 1'b0, look_valid_o)
        mreg(1, 32'h00000202, 32'h0);
        `CHK("simd_status", 32'h00001F80, model_reg_rdata_o)
        for (i = 0; i < 60; i = i + 1)
        begin
            r = lfsr(r);
            v = i == 0 ? 32'h00000024 : i == 1 ? 32'h0000000A : i == 2 ? 32'h00000008 : r;
            c = i < 3 ? 3'h7 : r[14:12];
            // The write strobe stays high across iterations so it is never raised and lowered in one step.
            wr_mcw_blk : begin
                mcw0_wr_i = 1;
                mcw0_wdata_i = v;
                tick;
            end
            {fp_op_i, pending_fp_check_op_i, fp_unmasked_err_i} = c;
            #1;
            `CHK("mcw0", v, mcw0_o)
            `CHK("fault", exp_fp(v, c), {dev_unavail_o, fp_err_internal_o, fp_err_external_o})
            `CHK("nofpu_fault", c[2] | (c[1] & v[1] & v[3]), nofpu_dev_unavail)
        end
        {fp_op_i, pending_fp_check_op_i, fp_unmasked_err_i} = 3'h0;
        mcw0_wr_i = 1;
        mcw0_wdata_i = 32'h0;
        tick;
        mcw0_wr_i = 0;
        mreg(0, 32'h00000200, 32'h00000006);
        page_write_through_i = 1;
        #1;
        `CHK("cacheable", 2'h3, {access_cacheable_o, access_write_through_o})
        page_cache_off_i = 1;
        #1;
        `CHK("page_off", 2'h0, {access_cacheable_o, access_write_through_o})
        page_cache_off_i = 0;
        range_type_sel_i = 8'h01;
        #1;
        `CHK("uncached", 1'b0, access_cacheable_o)
        fill_i = 1;
        fill_idx_i = 6'h05;
        look_idx_i = 6'h05;
        tick;
        fill_i = 0;
        tick;
        `CHK("filled", 1'b1, look_valid_o)
        ecw_wr_i = 1;
        ecw_wdata_i = 32'h00000200;
        ident_leaf_i = 32'h00000001;
        ident_query_i = 1;
        tick;
        ecw_wr_i = 0;
        `CHK("simd_flags", 2'h1, {os_simd_fault_flag_o, os_simd_save_flag_o})
        `CHK("id_r1", 32'h07080000, ident_r1_o)
        `CHK("id_r2", 32'h00000001, ident_r2_o)
        ident_leaf_i = 32'h00000002;
        tick;
        ident_query_i = 0;
        `CHK("id_other", 32'h0, ident_r1_o)
        mreg(1, 32'h00000300, 32'h0);
        `CHK("msr_fault", 1'b1, model_reg_fault_o)
        tick;
        mreg(0, 32'h00000202, 32'h00001234);
        soft_init_i = 1;
        tick;
        soft_init_i = 0;
        `CHK("soft_mcw0", 32'h00000010, mcw0_o)
        mreg(1, 32'h00000202, 32'h0);
        `CHK("soft_status", 32'h00001234, model_reg_rdata_o)
        end_sim;
    end
endmodule
